/* hw/dps_pkg.sv */
package dps_pkg;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam int BYTE_W = 8;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int ADDR_W = 4;
    localparam int SLOTS = 4;
    localparam int POTS = 2;
    // Selection byte: type code high nibble, slave address low nibble
    localparam int ID_TYPE_MSB = 7;
    localparam int ID_TYPE_LSB = 4;
    localparam int ID_ADDR_MSB = 3;
    localparam int ID_ADDR_LSB = 0;
    // Command byte: opcode, slot, pot
    localparam int CMD_OP_MSB = 7;
    localparam int CMD_OP_LSB = 5;
    localparam int CMD_SLOT_MSB = 3;
    localparam int CMD_SLOT_LSB = 2;
    localparam int CMD_POT_BIT = 0;
    // Device type code, value arbitrary
    localparam logic [3:0] DEV_TYPE = 4'hA;

    // ****************************************
    // Commands
    // ****************************************
    localparam logic [2:0] OP_RD_WIPER = 3'h0;
    localparam logic [2:0] OP_WR_WIPER = 3'h1;
    localparam logic [2:0] OP_RD_STORE = 3'h2;
    localparam logic [2:0] OP_WR_STORE = 3'h3;
    localparam logic [2:0] OP_STORE_TO_WIPER = 3'h4;
    localparam logic [2:0] OP_WIPER_TO_STORE = 3'h5;
    localparam logic [2:0] OP_RD_STATUS = 3'h6;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [1:0] DEFAULT_STORE_SLOT = 2'h0;
    localparam logic [7:0] STORE_RESET = 8'h80;
    localparam int CLK_HZ = 20_000_000;
    localparam int NVM_WRITE_MS = 10;
    localparam int NVM_WRITE_CYCLES = NVM_WRITE_MS * (CLK_HZ / 1000);

    typedef enum logic [1:0] {
        ST_SELECT,
        ST_COMMAND,
        ST_DATA,
        ST_IGNORE
    } dps_state_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic pause_n;
        logic wp_n;
        logic [ADDR_W-1:0] addr_strap;
    } dps_pins_t;

    // Idle pin levels, so no false edge follows reset
    localparam dps_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, pause_n: 1'b1, wp_n: 1'b1, addr_strap: '0};

    typedef struct packed {
        logic [BYTE_W-1:0] tap1;
        logic [BYTE_W-1:0] tap0;
    } dps_taps_t;

endpackage

/* hw/dps_serial_front_end.sv */
`timescale 1ns/1ns

module dps_serial_front_end #(
    parameter int NVM_WRITE_CYCLES = dps_pkg::NVM_WRITE_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire dps_pkg::dps_pins_t pins,
    output logic so_out,
    output logic so_oe_n,
    output dps_pkg::dps_taps_t taps,
    output logic nvm_write_pending
);

    localparam int TW = $clog2(NVM_WRITE_CYCLES + 1);
    localparam int PW = $bits(dps_pkg::dps_pins_t);

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic [PW-1:0] sync1;
    logic [PW-1:0] sync2;
    logic sck_prev;
    logic cs_prev;
    dps_pkg::dps_pins_t p;

    assign p = dps_pkg::dps_pins_t'(sync2);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1 <= dps_pkg::PINS_IDLE;
            sync2 <= dps_pkg::PINS_IDLE;
            sck_prev <= 1'b0;
            cs_prev <= 1'b1;
        end
        else if (clk_en)
        begin
            sync1 <= pins;
            sync2 <= sync1;
            sck_prev <= p.sck;
            cs_prev <= p.cs_n;
        end
    end

    logic active;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;

    // Paused: edges are ignored, sequence state simply stands
    assign active = !p.cs_n && p.pause_n;
    assign sck_rise = active && p.sck && !sck_prev;
    assign sck_fall = active && !p.sck && sck_prev;
    assign cs_fall = cs_prev && !p.cs_n;

    // ****************************************
    // Serial receive state
    // ****************************************
    dps_pkg::dps_state_t state;
    logic armed;
    logic [2:0] bit_cnt;
    logic [dps_pkg::BYTE_W-1:0] in_sr;
    logic [dps_pkg::BYTE_W-1:0] rx_byte;
    logic byte_done;
    logic [2:0] op;
    logic [1:0] slot;
    logic pot;
    logic [dps_pkg::BYTE_W-1:0] out_sr;

    assign rx_byte = {in_sr[dps_pkg::BYTE_W-2:0], p.si};
    assign byte_done = sck_rise && (bit_cnt == dps_pkg::BIT_LAST);

    // Storage arrays
    logic [dps_pkg::BYTE_W-1:0] wiper [dps_pkg::POTS];
    logic [dps_pkg::BYTE_W-1:0] store [dps_pkg::POTS][dps_pkg::SLOTS];
    logic recall;
    logic [TW-1:0] nvm_timer;

    logic cmd_done;
    logic [2:0] cmd_op;
    logic [1:0] cmd_slot;
    logic cmd_pot;
    logic nvm_ok;
    logic start_nvm;

    assign cmd_done = byte_done && state == dps_pkg::ST_COMMAND;
    assign cmd_op = rx_byte[dps_pkg::CMD_OP_MSB:dps_pkg::CMD_OP_LSB];
    assign cmd_slot = rx_byte[dps_pkg::CMD_SLOT_MSB:dps_pkg::CMD_SLOT_LSB];
    assign cmd_pot = rx_byte[dps_pkg::CMD_POT_BIT];
    // Busy array refuses too, so a second write never shortens the first
    assign nvm_ok = p.wp_n && !nvm_write_pending;
    assign start_nvm = nvm_ok && ((byte_done && state == dps_pkg::ST_DATA && op == dps_pkg::OP_WR_STORE)
        || (cmd_done && cmd_op == dps_pkg::OP_WIPER_TO_STORE));

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= dps_pkg::ST_SELECT;
            armed <= 1'b0;
            bit_cnt <= '0;
            in_sr <= '0;
            op <= '0;
            slot <= '0;
            pot <= 1'b0;
        end
        else if (clk_en)
        begin
            if (p.cs_n)
            begin
                // Deselect abandons any sequence
                state <= dps_pkg::ST_SELECT;
                bit_cnt <= '0;
            end
            else if (cs_fall)
            begin
                armed <= 1'b1;
                state <= dps_pkg::ST_SELECT;
                bit_cnt <= '0;
            end
            else if (sck_rise && armed)
            begin
                in_sr <= rx_byte;
                bit_cnt <= bit_cnt + 3'h1;
                if (byte_done)
                begin
                    case (state)
                        dps_pkg::ST_SELECT:
                        begin
                            if (rx_byte[dps_pkg::ID_TYPE_MSB:dps_pkg::ID_TYPE_LSB] == dps_pkg::DEV_TYPE
                                && rx_byte[dps_pkg::ID_ADDR_MSB:dps_pkg::ID_ADDR_LSB] == p.addr_strap)
                                state <= dps_pkg::ST_COMMAND;
                            else
                                state <= dps_pkg::ST_IGNORE;
                        end
                        dps_pkg::ST_COMMAND:
                        begin
                            op <= cmd_op;
                            slot <= cmd_slot;
                            pot <= cmd_pot;
                            state <= dps_pkg::ST_DATA;
                        end
                        dps_pkg::ST_DATA:
                            state <= dps_pkg::ST_IGNORE;
                        default:
                            state <= dps_pkg::ST_IGNORE;
                    endcase
                end
            end
        end
    end

    // ****************************************
    // Wiper and stored settings
    // ****************************************
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            recall <= 1'b1;
            for (int i = 0; i < dps_pkg::POTS; i++)
            begin
                wiper[i] <= dps_pkg::STORE_RESET;
            end
        end
        else if (clk_en)
        begin
            if (recall)
            begin
                // Power-up recall of the default slot
                recall <= 1'b0;
                for (int i = 0; i < dps_pkg::POTS; i++)
                begin
                    wiper[i] <= store[i][dps_pkg::DEFAULT_STORE_SLOT];
                end
            end
            else if (byte_done && state == dps_pkg::ST_DATA && op == dps_pkg::OP_WR_WIPER)
                wiper[pot] <= rx_byte;
            else if (cmd_done && cmd_op == dps_pkg::OP_STORE_TO_WIPER)
                wiper[cmd_pot] <= store[cmd_pot][cmd_slot];
        end
    end

    // Stored settings persist across reset in the real array; here reset stands in for the erased state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < dps_pkg::POTS; i++)
            begin
                for (int j = 0; j < dps_pkg::SLOTS; j++)
                begin
                    store[i][j] <= dps_pkg::STORE_RESET;
                end
            end
        end
        else if (clk_en && start_nvm)
        begin
            if (state == dps_pkg::ST_DATA)
                store[pot][slot] <= rx_byte;
            else
                store[cmd_pot][cmd_slot] <= wiper[cmd_pot];
        end
    end

    // Write busy timer
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nvm_timer <= '0;
            nvm_write_pending <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start_nvm)
            begin
                nvm_timer <= TW'(NVM_WRITE_CYCLES - 1);
                nvm_write_pending <= 1'b1;
            end
            else if (nvm_write_pending)
            begin
                if (nvm_timer == '0)
                    nvm_write_pending <= 1'b0;
                else
                    nvm_timer <= nvm_timer - TW'(1);
            end
        end
    end

    generate
        for (genvar g = 0; g < dps_pkg::POTS; g++)
        begin : g_tap
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    taps[g*dps_pkg::BYTE_W +: dps_pkg::BYTE_W] <= dps_pkg::STORE_RESET;
                else if (clk_en)
                    taps[g*dps_pkg::BYTE_W +: dps_pkg::BYTE_W] <= wiper[g];
            end
        end
    endgenerate

    // ****************************************
    // Serial output
    // ****************************************
    logic rd_load;
    logic [dps_pkg::BYTE_W-1:0] rd_value;

    assign rd_load = cmd_done && (cmd_op == dps_pkg::OP_RD_WIPER || cmd_op == dps_pkg::OP_RD_STORE
        || cmd_op == dps_pkg::OP_RD_STATUS);

    always_comb
    begin
        case (cmd_op)
            dps_pkg::OP_RD_WIPER: rd_value = wiper[cmd_pot];
            dps_pkg::OP_RD_STORE: rd_value = store[cmd_pot][cmd_slot];
            default: rd_value = {{(dps_pkg::BYTE_W-1){1'b0}}, nvm_write_pending};
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_sr <= '0;
            so_out <= 1'b0;
            so_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            if (p.cs_n || !p.pause_n || state != dps_pkg::ST_DATA)
                so_oe_n <= 1'b1;
            if (rd_load)
                out_sr <= rd_value;
            else if (sck_fall && state == dps_pkg::ST_DATA && op != dps_pkg::OP_WR_WIPER
                && op != dps_pkg::OP_WR_STORE && op != dps_pkg::OP_STORE_TO_WIPER
                && op != dps_pkg::OP_WIPER_TO_STORE)
            begin
                so_out <= out_sr[dps_pkg::BYTE_W-1];
                so_oe_n <= 1'b0;
                out_sr <= {out_sr[dps_pkg::BYTE_W-2:0], 1'b0};
            end
        end
    end

endmodule

/* bench/dps_host_model.sv */
`timescale 1ns/1ns
module dps_host_model (
    input wire logic clk,
    input wire logic so_out,
    input wire logic so_oe_n,
    output dps_pkg::dps_pins_t pins,
    output logic rd_valid,
    output logic [7:0] rd_data
);
    logic so_wire;
    // *****
    // Serial master, mode 0
    // *****
    assign so_wire = so_oe_n ? 1'b1 : so_out; // Pull-up holds the floating line
    initial
    begin
        pins = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0};
        rd_valid = 1'b0;
        rd_data = 8'h00;
    end
    task automatic half();
        repeat (4) @(negedge clk);
    endtask
    task automatic frame(input logic [23:0] bits, input int nbits, input int pz, input logic rd);
        logic [7:0] sh;
        sh = 8'h00;
        pins.cs_n = 1'b0;
        half();
        for (int i = 0; i < nbits; i++)
        begin
            pins.si = bits[23-i];
            half();
            pins.sck = 1'b1;
            sh = {sh[6:0], so_wire};
            half();
            pins.sck = 1'b0;
            if (i == pz)
            begin
                half();
                pins.pause_n = 1'b0;
                half();
                pins.sck = 1'b1;
                pins.si = ~pins.si;
                half();
                pins.sck = 1'b0;
                half();
                pins.pause_n = 1'b1;
                half();
            end
        end
        half();
        pins.cs_n = 1'b1;
        pins.si = ~pins.si; // Released line does not keep the last bit
        rd_data = sh;
        rd_valid = rd;
        @(negedge clk);
        rd_valid = 1'b0;
        half();
    endtask
endmodule

/* bench/dps_checker.sv */
`timescale 1ns/1ns
module dps_checker #(
    parameter int NVM_WRITE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire dps_pkg::dps_pins_t pins,
    input wire logic so_out,
    input wire logic so_oe_n,
    input wire dps_pkg::dps_taps_t taps,
    input wire logic nvm_write_pending
);
    int pend_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pend_cnt <= 0;
        else
            pend_cnt <= !clk_en ? pend_cnt : (nvm_write_pending ? pend_cnt + 1 : 0);
    end
    a_desel_float: assert property (pins.cs_n [*5] |-> so_oe_n) else $error("output driven while deselected");
    a_pause_float: assert property (!pins.pause_n [*5] |-> so_oe_n) else $error("output driven while paused");
    a_out_on_fall: assert property (!so_oe_n && $changed(so_out) |-> !$past(pins.sck))
        else $error("output changed outside clock low");
    a_oe_on_fall: assert property ($fell(so_oe_n) |-> !$past(pins.sck) && !pins.cs_n)
        else $error("output enabled outside clock low");
    a_pend_bound: assert property (pend_cnt <= NVM_WRITE_CYCLES) else $error("write pending too long");
    a_pend_exact: assert property ($fell(nvm_write_pending) |-> pend_cnt == NVM_WRITE_CYCLES)
        else $error("write pending length wrong");
    a_guard_write: assert property ($rose(nvm_write_pending) |-> $past(pins.wp_n, 3))
        else $error("stored write while guarded");
    a_one_pot: assert property ($changed(taps.tap0) |-> $stable(taps.tap1)) else $error("both taps moved");
    a_recall: assert property ($rose(arst_n) |-> ##2 taps == {dps_pkg::STORE_RESET, dps_pkg::STORE_RESET})
        else $error("default slot not recalled");
endmodule

/* bench/test_dual_pot_serial_front_end.sv */
`timescale 1ns/1ns
module test_dual_pot_serial_front_end;
    localparam int NVM = 400;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    dps_pkg::dps_pins_t pins;
    dps_pkg::dps_taps_t taps;
    logic so_out, so_oe_n, nvm_write_pending, rd_valid;
    logic [7:0] rd_data;
    logic [15:0] exp_e;
    logic [3:0] sa;
    logic [31:0] rs = 32'h00015DBA;
    logic [15:0] exp_q[$];
    logic [7:0] store [2][4];
    logic [7:0] wiper [2];
    int error_cnt = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    dps_serial_front_end #(.NVM_WRITE_CYCLES(NVM)) u_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
        .pins(pins), .so_out(so_out), .so_oe_n(so_oe_n), .taps(taps), .nvm_write_pending(nvm_write_pending));
    dps_host_model u_host (.clk(clk), .so_out(so_out), .so_oe_n(so_oe_n), .pins(pins),
        .rd_valid(rd_valid), .rd_data(rd_data));
    // *****
    // Helpers
    // *****
    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return 8'(rs);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic op(input logic [2:0] c, input logic [1:0] s, input logic p, input logic [7:0] d,
        input logic [3:0] a, input logic [7:0] m, input int pz);
        if (m != 8'h00)
            exp_q.push_back({m, d & m});
        u_host.frame({dps_pkg::DEV_TYPE, a, c, 1'b0, s, 1'b0, p, d}, (c == 3'h4 || c == 3'h5) ? 16 : 24,
            pz, m != 8'h00);
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 1000 && nvm_write_pending !== 1'b0; n++)
            @(negedge clk);
        if (n == 1000)
        begin
            check(16'h0001, 16'h0000);
            end_of_test();
        end
    endtask
    // *****
    // Result watcher
    // *****
    always @(posedge clk)
    begin
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(16'h0001, 16'h0000);
            else
            begin
                exp_e = exp_q.pop_front();
                check({8'h00, rd_data & exp_e[15:8]}, {8'h00, exp_e[7:0]});
            end
        end
    end
    // *****
    // Scenarios
    // *****
    initial
    begin
        sa = 4'(rnd());
        repeat (20) @(negedge clk);
        u_host.pins.addr_strap = sa;
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        check(taps, 16'h8080);
        for (int i = 0; i < 8; i++)
        begin
            store[i/4][i%4] = dps_pkg::STORE_RESET;
            op(dps_pkg::OP_RD_STORE, 2'(i), 1'(i / 4), dps_pkg::STORE_RESET, sa, 8'hFF, 99);
        end
        for (int p = 0; p < 2; p++)
        begin
            wiper[p] = rnd();
            op(dps_pkg::OP_WR_WIPER, 2'h0, 1'(p), wiper[p], sa, 8'h00, 11 + p);
        end
        check(taps, {wiper[1], wiper[0]});
        op(dps_pkg::OP_WR_WIPER, 2'h0, 1'b0, ~wiper[0], sa ^ 4'h1, 8'h00, 99);
        check(taps, {wiper[1], wiper[0]});
        op(dps_pkg::OP_RD_WIPER, 2'h0, 1'b1, 8'hFF, sa ^ 4'h8, 8'hFF, 99);
        op(dps_pkg::OP_RD_WIPER, 2'h0, 1'b1, wiper[1], sa, 8'hFF, 99);
        for (int s = 0; s < 4; s++)
        begin
            store[1][s] = rnd();
            op(dps_pkg::OP_WR_STORE, 2'(s), 1'b1, store[1][s], sa, 8'h00, 99);
            op(dps_pkg::OP_RD_STATUS, 2'h0, 1'b0, 8'h01, sa, 8'h01, 99);
            wait_idle();
            op(dps_pkg::OP_RD_STATUS, 2'h0, 1'b0, 8'h00, sa, 8'h01, 99);
            op(dps_pkg::OP_RD_STORE, 2'(s), 1'b1, store[1][s], sa, 8'hFF, 99);
        end
        u_host.pins.wp_n = 1'b0;
        op(dps_pkg::OP_WR_STORE, 2'h0, 1'b1, ~store[1][0], sa, 8'h00, 99);
        check({15'h0000, nvm_write_pending}, 16'h0000);
        u_host.pins.wp_n = 1'b1;
        op(dps_pkg::OP_RD_STORE, 2'h0, 1'b1, store[1][0], sa, 8'hFF, 99);
        op(dps_pkg::OP_STORE_TO_WIPER, 2'h2, 1'b1, 8'h00, sa, 8'h00, 99);
        check(taps, {store[1][2], wiper[0]});
        op(dps_pkg::OP_WIPER_TO_STORE, 2'h3, 1'b0, 8'h00, sa, 8'h00, 99);
        // Frozen longer than the busy time: pending must still stand
        clk_en = 1'b0;
        repeat (500) @(negedge clk);
        check({15'h0000, nvm_write_pending}, 16'h0001);
        clk_en = 1'b1;
        wait_idle();
        op(dps_pkg::OP_RD_STORE, 2'h3, 1'b0, wiper[0], sa, 8'hFF, 99);
        arst_n = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        check(taps, 16'h8080);
        check(16'(exp_q.size()), 16'h0000);
        end_of_test();
    end
endmodule
bind dps_serial_front_end dps_checker #(.NVM_WRITE_CYCLES(NVM_WRITE_CYCLES)) u_chk (.clk(clk), .arst_n(arst_n),
    .clk_en(clk_en), .pins(pins), .so_out(so_out), .so_oe_n(so_oe_n), .taps(taps),
    .nvm_write_pending(nvm_write_pending));
